// file: verilog/region_select.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "region_select_defines.svh"

// Summary of operation
// R1: Upper select active at reset, 64K top.
// R2: Upper region always ends at top.
// R3: Bound field picks upper region start.
// R4: Upper control register resets to f03b.
// R5: Drive-disable bit floats bus address phase.
// R6: Upper drive-disable clears at reset.
// R7: Upper address outputs still drive data phase.
// R8: Strap low forces address drive always.
// R9: Strap high lets drive-disable bits govern.
// R10: Ready mode bit selects external ready.
// R11: Wait field inserts zero to three waits.
// R12: Upper ready mode 0, waits 3 reset.
// R13: Lower select enabled by first write.
// R14: Lower control register reset value arbitrary.
// R15: Bound field picks lower region end.
// R16: Lower psram enable bit stored, exported.
// R17: Software configures refresh before psram enable.
// R18: Software writes reserved upper bits correctly.
// R19: Lower region always starts at zero.
// R20: Ready sampled first wait; remaining waits follow.
// R21: Selects assert with demuxed address timing.
// R22: Ready may come from either input.
// R23: Selects only on memory cycles in range.
// R24: Writes apply to cycles starting later.
module region_select
  import region_select_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Processor bus cycle request.
  input  wire logic        cycle_start_i,
  input  wire logic        cycle_is_mem_i,
  input  wire mem_addr_t   nonmuxed_addr_bus_i,
  input  wire logic        async_ready_in_i,
  input  wire logic        sync_ready_in_i,
  input  wire logic        address_enable_strap_i,
  // Outputs to memories and bus drivers.
  output logic             upper_region_select_b_o,
  output logic             lower_region_select_b_o,
  output logic             muxed_addr_drive_o,
  output logic             upper_addr_drive_o,
  output logic             cycle_done_o,
  output logic             psram_mode_o
);

  logic [15:0]  upper_region_select_ctrl_reg;
  logic [15:0]  lower_region_select_ctrl_reg;
  logic         lower_enabled_reg;
  logic         strap_high_reg;
  logic         strap_taken_reg;
  cycle_state_e state_reg;
  wait_count_t  wait_left_reg;
  logic         need_ready_reg;
  logic         disable_reg;
  logic [15:0]  upper_snap_reg;
  logic [15:0]  lower_snap_reg;
  logic         upper_hit;
  logic         lower_hit;
  logic         ready_any;
  logic         apb_write;
  logic         apb_setup;
  logic         upper_ctrl_wr;
  logic         lower_ctrl_wr;
  logic [31:0]  prdata_next;
  logic         addr_ok;
  logic [1:0]   region_hit;
  logic [1:0]   region_sel_next;

  assign ready_any  = async_ready_in_i | sync_ready_in_i; // R22
  assign apb_write  = psel && penable && pwrite;
  assign apb_setup  = psel && !penable;
  assign region_hit = {upper_hit, lower_hit};

  // Write strobes; a write lands at the edge that ends the access phase.
  assign upper_ctrl_wr = apb_write && (paddr == `UPPER_CTRL_ADDR);
  assign lower_ctrl_wr = apb_write && (paddr == `LOWER_CTRL_ADDR);

  // Decode sees the settings of the edge that starts the cycle, as the snapshot does.
  // A start that arrives while a cycle runs is ignored and leaves the hits alone.
  region_decode region_decode_i (
    .clk_i               (clk_i),
    .rst_b_i             (rst_b_i),
    .addr_i              (nonmuxed_addr_bus_i),
    .mem_cycle_i         (cycle_start_i && cycle_is_mem_i && state_reg == ST_IDLE),
    .lower_bound_field_i (upper_region_select_ctrl_reg[`BOUND_HI:`BOUND_LO]),
    .upper_bound_field_i (lower_region_select_ctrl_reg[`BOUND_HI:`BOUND_LO]),
    .lower_enabled_i     (lower_enabled_reg),
    .upper_hit_o         (upper_hit),
    .lower_hit_o         (lower_hit)
  );

  // Upper control register with its documented reset value.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_region_select_ctrl_reg <= `UPPER_CTRL_RESET; // R1 R4 R6 R12
    end else if (upper_ctrl_wr) begin
      upper_region_select_ctrl_reg <= pwdata[15:0];
    end
  end

  // Lower control register; its reset value carries no meaning.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lower_region_select_ctrl_reg <= `LOWER_CTRL_RESET; // R14
    end else if (lower_ctrl_wr) begin
      lower_region_select_ctrl_reg <= pwdata[15:0];
    end
  end

  // Any write to the lower control register enables the lower select.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lower_enabled_reg <= 1'b0;
    end else if (lower_ctrl_wr) begin
      lower_enabled_reg <= 1'b1; // R13
    end
  end

  // Strap is caught on the first clock after reset release.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_taken_reg <= 1'b0;
      strap_high_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_high_reg  <= address_enable_strap_i; // R8 R9
    end
  end

  // APB answers in the access phase with zero waits.
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      `UPPER_CTRL_ADDR: prdata_next = {16'h0000, upper_region_select_ctrl_reg};
      `LOWER_CTRL_ADDR: prdata_next = {16'h0000, lower_region_select_ctrl_reg};
      `STATUS_ADDR:     prdata_next = {26'h0000000, state_reg, lower_enabled_reg,
                                       upper_hit, lower_hit};
      `STRAP_ADDR:      prdata_next = {31'h00000000, strap_high_reg};
      default: begin
        prdata_next = 32'h00000000;
        addr_ok     = 1'b0;
      end
    endcase
  end

  // Registered read data and error flag, valid when pready is high.
  // Read data is zero outside that cycle so stale values never linger.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      prdata  <= (apb_setup && !pwrite) ? prdata_next : 32'h00000000;
    end
  end

  // Settings are snapped at cycle start so writes apply to later cycles.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_snap_reg <= `UPPER_CTRL_RESET;
      lower_snap_reg <= `LOWER_CTRL_RESET;
    end else if (state_reg == ST_IDLE && cycle_start_i) begin
      upper_snap_reg <= upper_region_select_ctrl_reg; // R24
      lower_snap_reg <= lower_region_select_ctrl_reg;
    end
  end

  // Bus cycle sequencer: address, waits, ready hold, tail wait, data.
  // Ready is looked at only in the first wait; a late ready is followed by
  // the remaining programmed waits before the data cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg      <= ST_IDLE;
      wait_left_reg  <= 2'h0;
      need_ready_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: if (cycle_start_i) begin
          state_reg <= ST_ADDR;
        end
        ST_ADDR: begin
          if (upper_hit) begin
            wait_left_reg  <= upper_snap_reg[`WAIT_HI:`WAIT_LO]; // R11
            need_ready_reg <= !upper_snap_reg[`READY_MODE_BIT]; // R10
          end else if (lower_hit) begin
            wait_left_reg  <= lower_snap_reg[`WAIT_HI:`WAIT_LO]; // R11
            need_ready_reg <= !lower_snap_reg[`READY_MODE_BIT]; // R10
          end else begin
            wait_left_reg  <= 2'h0;
            need_ready_reg <= 1'b0;
          end
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_left_reg == 2'h0) begin
            state_reg <= ST_DATA;
          end else if (need_ready_reg && !ready_any) begin
            state_reg <= ST_READY; // R20
          end else begin
            wait_left_reg <= wait_left_reg - 2'h1;
          end
          if (wait_left_reg != 2'h0) begin
            need_ready_reg <= 1'b0;
          end
        end
        ST_READY: if (ready_any) begin
          wait_left_reg <= wait_left_reg - 2'h1;
          state_reg     <= ST_TAIL; // R20
        end
        ST_TAIL: state_reg <= (wait_left_reg == 2'h0) ? ST_DATA : ST_TAIL;
        ST_DATA: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
      if (state_reg == ST_TAIL && wait_left_reg != 2'h0) begin
        wait_left_reg <= wait_left_reg - 2'h1;
      end
    end
  end

  // Address-phase float decision from the hit region and strap.
  // With the strap caught low the bus is always driven, whatever the
  // drive-disable bits say.
  always_comb begin
    disable_reg = strap_high_reg && // R8 R9
                  ((upper_hit && upper_snap_reg[`DRIVE_DIS_BIT]) ||
                   (lower_hit && lower_snap_reg[`DRIVE_DIS_BIT])); // R5
  end

  // Each select is held from its decode edge until the data cycle is over.
  // Bit 1 is the upper region, bit 0 the lower one.
  generate
    for (genvar g = 0; g < 2; g++) begin : g_region
      logic live_reg;

      // Remembers whether this region was hit in the address cycle.
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          live_reg <= 1'b0;
        end else if (state_reg == ST_ADDR) begin
          live_reg <= region_hit[g]; // R23
        end else if (state_reg == ST_DATA) begin
          live_reg <= 1'b0;
        end
      end

      // Asserted from the address cycle through the data cycle.
      assign region_sel_next[g] = (region_hit[g] && state_reg == ST_ADDR) ||
                                  (live_reg && state_reg != ST_IDLE); // R21
    end
  endgenerate

  // Registered select pins, active low, following the demuxed address decode.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_region_select_b_o <= 1'b1;
      lower_region_select_b_o <= 1'b1;
    end else begin
      upper_region_select_b_o <= !region_sel_next[1]; // R21 R23
      lower_region_select_b_o <= !region_sel_next[0]; // R21 R23
    end
  end

  // Bus drive enables; the muxed bus is driven only in the address phase, unless drive-disable floats it there.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      muxed_addr_drive_o <= 1'b0;
      upper_addr_drive_o <= 1'b0;
    end else begin
      muxed_addr_drive_o <= (state_reg == ST_ADDR) && !disable_reg; // R5
      upper_addr_drive_o <= (state_reg == ST_ADDR && !disable_reg) ||
                            (state_reg != ST_IDLE && state_reg != ST_ADDR); // R7
    end
  end

  // Cycle end pulse and the pseudo-static mode flag of the lower region.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycle_done_o <= 1'b0;
      psram_mode_o <= 1'b0;
    end else begin
      cycle_done_o <= (state_reg == ST_DATA);
      psram_mode_o <= lower_enabled_reg &&
                      lower_region_select_ctrl_reg[`PSRAM_EN_BIT]; // R16
    end
  end

endmodule : region_select

// file: shared/region_select_defines.svh
`ifndef REGION_SELECT_DEFINES_SVH
`define REGION_SELECT_DEFINES_SVH

// Register indices; some are not word aligned.
`define UPPER_CTRL_INDEX  12'h0a0
`define LOWER_CTRL_INDEX  12'h0a2
`define STATUS_INDEX      12'h0a4
`define STRAP_INDEX       12'h0a8

// Byte addresses on the register bus: one aligned word per index.
`define UPPER_CTRL_ADDR   12'h280
`define LOWER_CTRL_ADDR   12'h288
`define STATUS_ADDR       12'h290
`define STRAP_ADDR        12'h2a0

// Control register fields.
`define BOUND_HI          14
`define BOUND_LO          12
`define DRIVE_DIS_BIT     7
`define PSRAM_EN_BIT      6
`define READY_MODE_BIT    2
`define WAIT_HI           1
`define WAIT_LO           0

// Reset value of the upper control register.
`define UPPER_CTRL_RESET  16'hf03b
`define LOWER_CTRL_RESET  16'h0000

`endif

// file: shared/region_select_pkg.sv
package region_select_pkg;

  // Bus cycle sequencer states, Gray coded from ST_IDLE to ST_DATA; the return to ST_IDLE flips all three bits.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WAIT  = 3'b011,
    ST_READY = 3'b010,
    ST_TAIL  = 3'b110,
    ST_DATA  = 3'b111
  } cycle_state_e;

  typedef logic [19:0] mem_addr_t;
  typedef logic [1:0]  wait_count_t;

endpackage : region_select_pkg

// file: verilog/region_decode.sv
`timescale 1ns/1ps
`include "region_select_defines.svh"

// Registered decode of one address against both regions.
module region_decode
  import region_select_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk_i,
  input  wire logic      rst_b_i,
  // Address and region settings.
  input  wire mem_addr_t addr_i,
  input  wire logic      mem_cycle_i,
  input  wire logic [2:0] lower_bound_field_i,
  input  wire logic [2:0] upper_bound_field_i,
  input  wire logic      lower_enabled_i,
  // Registered hits.
  output logic           upper_hit_o,
  output logic           lower_hit_o
);

  logic [3:0] top_nibble;
  logic       upper_hit_next;
  logic       lower_hit_next;

  // The upper region ends at the top; the lower one starts at zero.
  always_comb begin
    top_nibble     = addr_i[19:16];
    upper_hit_next = mem_cycle_i && top_nibble[3] &&
                     ((top_nibble[2:0] & lower_bound_field_i) == lower_bound_field_i); // R2 R3
    lower_hit_next = mem_cycle_i && lower_enabled_i && !top_nibble[3] &&
                     ((top_nibble[2:0] & ~upper_bound_field_i) == 3'h0); // R15 R19 R23
  end

  // Hits are held in flip-flops.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_hit_o <= 1'b0;
      lower_hit_o <= 1'b0;
    end else begin
      upper_hit_o <= upper_hit_next;
      lower_hit_o <= lower_hit_next;
    end
  end

endmodule : region_decode

// file: tb/region_select_monitor.sv
`timescale 1ns/1ps
`include "region_select_defines.svh"
// Watches the block's register bus and select outputs.
module region_select_monitor
  import region_select_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bus cycles and selects.
  input wire logic        cycle_start_i,
  input wire logic        cycle_is_mem_i,
  input wire mem_addr_t   nonmuxed_addr_bus_i,
  input wire logic        upper_region_select_b_o,
  input wire logic        lower_region_select_b_o,
  input wire logic        cycle_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_SEL_EXCL: assert property (upper_region_select_b_o || lower_region_select_b_o)
    else $error("both selects active");
  AST_IO_NO_SEL: assert property (cycle_start_i && !cycle_is_mem_i |=>
    (upper_region_select_b_o && lower_region_select_b_o) [*4]) else $error("select in io cycle");
  AST_UPPER_HIT: assert property (cycle_start_i && cycle_is_mem_i &&
    nonmuxed_addr_bus_i[19:16] == 4'hf |-> ##[1:3] !upper_region_select_b_o)
    else $error("top of memory not selected");
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no answer in access phase");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  AST_SLVERR: assert property (pready |->
    pslverr == !(paddr inside {`UPPER_CTRL_ADDR, `LOWER_CTRL_ADDR, `STATUS_ADDR,
                               `STRAP_ADDR})) else $error("bad error flag");
  AST_RDATA: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  AST_MIN_CYCLE: assert property (cycle_start_i |=> !cycle_done_o [*2])
    else $error("bus cycle ended too soon");
endmodule : region_select_monitor

// file: tb/memory_model.sv
`timescale 1ns/1ps
// Slow memory: raises ready a set number of cycles after being selected.
module memory_model (
  // Clock, reset and selects.
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       upper_b_i,
  input  wire logic       lower_b_i,
  // Speed setting.
  input  wire logic [3:0] stall_i,
  input  wire logic       use_async_i,
  // Ready lines.
  output logic            async_ready_o,
  output logic            sync_ready_o
);
  logic [3:0] wait_reg;
  logic       ready;
  // Counts cycles since selection; unselected parts never claim ready.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wait_reg <= 4'h0;
    else if (upper_b_i && lower_b_i) wait_reg <= 4'h0;
    else if (wait_reg != 4'hf) wait_reg <= wait_reg + 4'h1;
  end
  // Ready reaches the block on one input or the other.
  assign ready         = !(upper_b_i && lower_b_i) && (wait_reg >= stall_i);
  assign async_ready_o = use_async_i & ready;
  assign sync_ready_o  = !use_async_i & ready;
endmodule : memory_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "region_select_defines.svh"
module tb_top;
  import region_select_pkg::*;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, async_ready_in_i, sync_ready_in_i, su, sl, drv, udrv;
  logic        cycle_start_i = 1'b0, cycle_is_mem_i = 1'b0, address_enable_strap_i = 1'b1;
  mem_addr_t   nonmuxed_addr_bus_i = 20'h00000;
  logic        upper_region_select_b_o, lower_region_select_b_o, muxed_addr_drive_o;
  logic        upper_addr_drive_o, cycle_done_o, psram_mode_o, use_async = 1'b0;
  logic [3:0]  stall = 4'h0;
  logic [2:0]  lbv [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
  int          bad_count = 0, checked = 0, cyc = 0, len, l0;

  region_select region_select_i (.*);
  memory_model memory_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .upper_b_i(upper_region_select_b_o), .lower_b_i(lower_region_select_b_o), .stall_i(stall),
    .use_async_i(use_async), .async_ready_o(async_ready_in_i), .sync_ready_o(sync_ready_in_i));

  // Clock at 40 MHz.
  always #12.5 clk_i = !clk_i;

  task give_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : check

  task do_reset(input logic s);
    rst_b_i <= 1'b0;
    address_enable_strap_i <= s;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  // One register bus transfer; holds the request until the answer edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  // Runs one bus cycle and records its length and what was seen.
  task run_cycle(input logic [19:0] a, input logic m);
    len = 0;
    {su, sl, drv, udrv} = 4'h0;
    cycle_start_i <= 1'b1;
    cycle_is_mem_i <= m;
    nonmuxed_addr_bus_i <= a;
    @(posedge clk_i);
    cycle_start_i <= 1'b0;
    while (cycle_done_o !== 1'b1 && len < 60) begin
      @(posedge clk_i);
      len++;
      su |= upper_region_select_b_o === 1'b0;
      sl |= lower_region_select_b_o === 1'b0;
      drv |= muxed_addr_drive_o === 1'b1;
      udrv |= upper_addr_drive_o === 1'b1;
    end
    if (len >= 60) bad_count++;
    @(posedge clk_i);
  endtask : run_cycle

  // Main sequence of tests.
  initial begin
    do_reset(1'b1);
    apb(1'b0, `UPPER_CTRL_ADDR, 32'h0); check(q, 32'h0000f03b);
    apb(1'b0, `STRAP_ADDR, 32'h0); check(q, 32'h1);
    apb(1'b0, 12'h0b0, 32'h0); check(e, 1'b1);
    stall <= 4'h2;
    run_cycle(20'hffff0, 1'b1); check({su, sl}, 2'b10);
    run_cycle(20'h00100, 1'b1); check({su, sl}, 2'b00);
    run_cycle(20'hf0000, 1'b0); check({su, sl}, 2'b00);
    $display("test reset done");
    foreach (lbv[i]) begin
      apb(1'b1, `UPPER_CTRL_ADDR, 32'h803c | (32'(lbv[i]) << 12));
      run_cycle({1'b1, lbv[i], 16'h0}, 1'b1); check(su, 1'b1);
      run_cycle({1'b1, lbv[i], 16'h0} - 20'h1, 1'b1); check(su, 1'b0);
      run_cycle(20'hfffff, 1'b1); check(su, 1'b1);
    end
    foreach (lbv[i]) begin
      apb(1'b1, `LOWER_CTRL_ADDR, 32'h0f3c | (32'(lbv[i] ^ 3'h7) << 12));
      run_cycle({1'b0, ~lbv[i], 16'hffff}, 1'b1); check(sl, 1'b1);
      run_cycle({1'b0, ~lbv[i], 16'hffff} + 20'h1, 1'b1); check(sl, 1'b0);
      run_cycle(20'h00000, 1'b1); check(sl, 1'b1);
    end
    $display("test bounds done");
    stall <= 4'h8;
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, `UPPER_CTRL_ADDR, 32'hf03c | w);
      run_cycle(20'hffff0, 1'b1);
      if (w == 0) l0 = len;
      check(len - l0, w);
    end
    apb(1'b1, `UPPER_CTRL_ADDR, 32'hf03a);
    stall <= 4'h0; run_cycle(20'hffff0, 1'b1); l0 = len;
    stall <= 4'h8; run_cycle(20'hffff0, 1'b1); check(len > l0, 1'b1);
    use_async <= 1'b1; run_cycle(20'hffff0, 1'b1); check(len > l0, 1'b1);
    apb(1'b1, `UPPER_CTRL_ADDR, 32'hf038);
    stall <= 4'h0; run_cycle(20'hffff0, 1'b1); l0 = len;
    stall <= 4'h8; run_cycle(20'hffff0, 1'b1); check(len, l0);
    $display("test waits done");
    apb(1'b1, `UPPER_CTRL_ADDR, 32'hf0bc);
    run_cycle(20'hffff0, 1'b1); check({drv, udrv}, 2'b01);
    apb(1'b1, `UPPER_CTRL_ADDR, 32'hf03c);
    run_cycle(20'hffff0, 1'b1); check(drv, 1'b1);
    apb(1'b1, `LOWER_CTRL_ADDR, 32'h0f7c);
    @(posedge clk_i); check(psram_mode_o, 1'b1);
    apb(1'b1, `LOWER_CTRL_ADDR, 32'h0f3c);
    @(posedge clk_i); check(psram_mode_o, 1'b0);
    do_reset(1'b0);
    apb(1'b0, `STRAP_ADDR, 32'h0); check(q, 32'h0);
    apb(1'b1, `UPPER_CTRL_ADDR, 32'hf0bc);
    run_cycle(20'hffff0, 1'b1); check(drv, 1'b1);
    $display("test drive done");
    give_verdict();
  end
endmodule : tb_top

bind region_select region_select_monitor region_select_monitor_i (.*);
